/* hw/sbd_alu.sv */
// subtract-with-borrow arithmetic with all six status results
// assumes purely combinational use inside the execution block
`timescale 1ns/1ps
module sbd_alu (
    // operands
    input wire logic [7:0] minuend_in,
    input wire logic [7:0] subtrahend_in,
    input wire logic carry_in,
    input wire logic prev_zero_in,
    // results
    output logic [7:0] diff_out,
    output logic carry_out,
    output logic half_borrow_out,
    output logic zero_out,
    output logic overflow_out,
    output logic signed_compare_out,
    output logic combined_zero_out
);
    import sbd_pkg::*;

    // borrow-in is the inverted carry
    wire logic borrow_in = ~carry_in;
    wire logic [8:0] full = {1'b0, minuend_in} - {1'b0, subtrahend_in} - {8'h00, borrow_in};
    wire logic [4:0] nib = {1'b0, minuend_in[SBD_NIB-1:0]}
        - {1'b0, subtrahend_in[SBD_NIB-1:0]} - {4'h0, borrow_in};

    // flags; carry means no borrow, so negative clears it
    assign diff_out = full[7:0];
    assign carry_out = ~full[8]; // RL2
    assign half_borrow_out = ~nib[SBD_NIB];
    assign zero_out = sbd_is_zero(full[7:0]);
    assign overflow_out = (minuend_in[7] ^ subtrahend_in[7]) & (minuend_in[7] ^ full[7]);
    assign signed_compare_out = overflow_out ^ full[7];
    // combined zero chains with the previous zero for multi-byte compares
    assign combined_zero_out = zero_out & prev_zero_in;

endmodule

/* hw/sbd_core.sv */
// execution block for subtract-with-borrow and decrement-skip
// assumes the decoder presents one operation per cycle, memory byte already read
`timescale 1ns/1ps
module sbd_core (
    // clock and reset
    input wire logic clock_in,
    input wire logic rst_in,
    // operation from the decoder
    input wire logic op_valid_in,
    input wire sbd_pkg::sbd_op_t op_in,
    input wire logic [7:0] imm_in,
    input wire logic [7:0] mem_data_in,
    // direct loads from other instructions
    input wire logic acc_load_in,
    input wire logic [7:0] acc_load_data_in,
    input wire logic carry_load_in,
    input wire logic carry_load_data_in,
    // accumulator and data memory write
    output logic [7:0] acc_out,
    output logic mem_wr_out,
    output logic [7:0] mem_wdata_out,
    // status flags
    output logic carry_flag_out,
    output logic half_borrow_flag_out,
    output logic zero_flag_out,
    output logic overflow_flag_out,
    output logic signed_compare_flag_out,
    output logic combined_zero_flag_out,
    // skip / dummy cycle indication
    output logic skip_out,
    output logic done_out
);
    import sbd_pkg::*;

    // state
    logic [7:0] accumulator_reg;
    logic [7:0] accumulator_next;
    logic carry_reg, half_borrow_reg, zero_reg, overflow_reg;
    logic signed_compare_reg, combined_zero_reg;
    logic mem_wr_reg, mem_wr_next;
    logic [7:0] mem_wdata_reg, mem_wdata_next;
    logic skip_reg, done_reg;
    sbd_state_t state_reg, state_next;

    // operation taken only outside the dummy cycle
    wire logic take = op_valid_in && (state_reg == SBD_ST_RUN);
    wire logic is_sub_acc = take && (op_in == SBD_OP_SUB_ACC);
    wire logic is_sub_mem = take && (op_in == SBD_OP_SUB_MEM);
    wire logic is_dec_mem = take && (op_in == SBD_OP_DEC_MEM);
    wire logic is_dec_acc = take && (op_in == SBD_OP_DEC_ACC);
    wire logic is_sub = is_sub_acc || is_sub_mem;
    wire logic is_dec = is_dec_mem || is_dec_acc;

    // subtrahend is immediate or memory byte
    wire logic [7:0] sub_operand = is_sub_acc ? imm_in : mem_data_in; // RL1 RL4

    logic [7:0] sub_diff;
    logic sub_c, sub_ac, sub_z, sub_ov, sub_sc, sub_cz;

    sbd_alu u_alu (
        .minuend_in(accumulator_reg),
        .subtrahend_in(sub_operand),
        .carry_in(carry_reg),
        .prev_zero_in(zero_reg),
        .diff_out(sub_diff),
        .carry_out(sub_c),
        .half_borrow_out(sub_ac),
        .zero_out(sub_z),
        .overflow_out(sub_ov),
        .signed_compare_out(sub_sc),
        .combined_zero_out(sub_cz)
    );

    // decrement of the addressed byte and its zero test
    wire logic [7:0] dec_value = mem_data_in - SBD_DEC_STEP; // RL5 RL6
    wire logic dec_zero = sbd_is_zero(dec_value);
    wire logic want_skip = is_dec && dec_zero; // RL5 RL6

    // accumulator source; an executing operation beats a direct load
    assign accumulator_next = is_sub_acc ? sub_diff : // RL1
        is_dec_acc ? dec_value : // RL6
        (!take && acc_load_in) ? acc_load_data_in :
        accumulator_reg; // RL4

    // memory write only for the memory-destination forms
    assign mem_wr_next = is_sub_mem || is_dec_mem; // RL4 RL5
    assign mem_wdata_next = is_sub_mem ? sub_diff : // RL4
        is_dec_mem ? dec_value : mem_wdata_reg; // RL5

    // a skip holds one dummy fetch cycle
    assign state_next = want_skip ? SBD_ST_DUMMY : SBD_ST_RUN; // RL7

    // accumulator and memory write port
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            accumulator_reg <= SBD_ACC_RST;
            mem_wr_reg <= 1'b0;
            mem_wdata_reg <= SBD_ZERO;
        end else begin
            accumulator_reg <= accumulator_next;
            mem_wr_reg <= mem_wr_next;
            mem_wdata_reg <= mem_wdata_next;
        end
    end

    // status flags; decrements leave them all alone
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            carry_reg <= SBD_FLAG_RST;
            half_borrow_reg <= SBD_FLAG_RST;
            zero_reg <= SBD_FLAG_RST;
            overflow_reg <= SBD_FLAG_RST;
            signed_compare_reg <= SBD_FLAG_RST;
            combined_zero_reg <= SBD_FLAG_RST;
        end else if (is_sub) begin
            carry_reg <= sub_c; // RL2 RL3
            half_borrow_reg <= sub_ac; // RL3
            zero_reg <= sub_z;
            overflow_reg <= sub_ov;
            signed_compare_reg <= sub_sc;
            combined_zero_reg <= sub_cz;
        end else if (!take && carry_load_in) begin
            carry_reg <= carry_load_data_in; // RL8
        end
    end

    // skip sequencer and completion pulse
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            state_reg <= SBD_ST_RUN;
            skip_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            skip_reg <= want_skip; // RL7
            done_reg <= take;
        end
    end

    // outputs straight from flops
    assign acc_out = accumulator_reg;
    assign mem_wr_out = mem_wr_reg;
    assign mem_wdata_out = mem_wdata_reg;
    assign carry_flag_out = carry_reg;
    assign half_borrow_flag_out = half_borrow_reg;
    assign zero_flag_out = zero_reg;
    assign overflow_flag_out = overflow_reg;
    assign signed_compare_flag_out = signed_compare_reg;
    assign combined_zero_flag_out = combined_zero_reg;
    assign skip_out = skip_reg;
    assign done_out = done_reg;

    // checks
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);

    // reference result by add-of-complement, independent of the alu form
    wire logic [8:0] ref_sum = {1'b0, accumulator_reg} + {1'b0, ~sub_operand} + {8'h00, carry_reg};
    // signed reference in ten bits: overflow when bits 8 and 7 differ, bit 8 is the true sign
    wire logic [9:0] ref_sdiff = {{2{accumulator_reg[7]}}, accumulator_reg}
        - {{2{sub_operand[7]}}, sub_operand} - {9'h000, ~carry_reg};
    wire logic ref_ov = ref_sdiff[8] ^ ref_sdiff[7];
    wire logic ref_sc = ref_sdiff[8];
    // low nibble by add-of-complement; bit 4 set means no half borrow
    wire logic [4:0] ref_nib = {1'b0, accumulator_reg[3:0]} + {1'b0, ~sub_operand[3:0]}
        + {4'h0, carry_reg};
    wire logic ref_hb = ref_nib[4];
    logic past_valid_reg;
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            past_valid_reg <= 1'b0;
        end else begin
            past_valid_reg <= 1'b1;
        end
    end

    // first cycle out of reset shows the cleared state
    a_reset_values: assert property (
        !past_valid_reg |-> acc_out == 8'h00 && !mem_wr_out && !skip_out && !done_out
            && !carry_flag_out && !zero_flag_out)
        else $error("state not cleared after reset");

    a_sub_acc_result: assert property ( // RL1
        is_sub_acc |=> acc_out == $past(ref_sum[7:0]))
        else $error("accumulator subtract result wrong");

    a_sub_carry_sign: assert property ( // RL2
        is_sub |=> carry_flag_out == $past(ref_sum[8]))
        else $error("carry after subtract wrong");

    a_sub_zero_flag: assert property ( // RL3
        is_sub |=> zero_flag_out == (($past(ref_sum[7:0])) == 8'h00))
        else $error("zero flag after subtract wrong");

    a_sub_flags_rest: assert property ( // RL3
        is_sub |=> overflow_flag_out == $past(ref_ov)
            && signed_compare_flag_out == $past(ref_sc)
            && half_borrow_flag_out == $past(ref_hb)
            && combined_zero_flag_out == (zero_flag_out && $past(zero_flag_out)))
        else $error("overflow, compare or half borrow flag after subtract wrong");

    a_sub_mem_keep: assert property ( // RL4
        is_sub_mem |=> mem_wr_out && mem_wdata_out == $past(ref_sum[7:0])
            && acc_out == $past(acc_out))
        else $error("memory subtract wrong or accumulator changed");

    a_dec_mem_write: assert property ( // RL5
        is_dec_mem |=> mem_wr_out && mem_wdata_out == $past(mem_data_in) - 8'h01
            && skip_out == (mem_wdata_out == 8'h00))
        else $error("memory decrement or skip wrong");

    a_dec_acc_only: assert property ( // RL6
        is_dec_acc |=> !mem_wr_out && acc_out == $past(mem_data_in) - 8'h01
            && skip_out == (acc_out == 8'h00))
        else $error("accumulator decrement wrong");

    a_skip_dummy_one: assert property ( // RL7
        skip_out |=> !done_out && !skip_out)
        else $error("dummy cycle not exactly one");

    a_skip_blocks_op: assert property ( // RL7
        (is_dec && mem_data_in == 8'h01) ##1 op_valid_in |=> !done_out && !mem_wr_out)
        else $error("operation taken during dummy cycle");

    a_dec_flags_hold: assert property ( // RL8
        is_dec && !carry_load_in |=> $stable({carry_flag_out, half_borrow_flag_out,
            zero_flag_out, overflow_flag_out, signed_compare_flag_out,
            combined_zero_flag_out}))
        else $error("decrement changed a status flag");

    c_sub_negative: cover property (is_sub_acc && !ref_sum[8]);
    c_dec_mem_skip: cover property (is_dec_mem && mem_data_in == 8'h01);
    c_dec_acc_noskip: cover property (is_dec_acc && mem_data_in != 8'h01);
    c_sub_mem_chain: cover property (is_sub_mem ##1 is_sub_mem);

endmodule

/* include/sbd_pkg.sv */
// package for the subtract-with-borrow and decrement-skip datapath
// assumes one core clock; decoder, data memory and status sit on it
// Overview of operation
// RL1: immediate subtract: acc minus imm minus not-carry
// RL2: carry cleared on negative, set otherwise
// RL3: subtracts update ov, z, ac, c, sc, cz
// RL4: memory subtract writes memory, accumulator untouched
// RL5: decrement memory, write back, skip on zero
// RL6: decrement into accumulator, memory untouched, skip zero
// RL7: skip inserts one dummy cycle, two cycles
// RL8: decrement-skip instructions never touch status flags
package sbd_pkg;

    // operation width of the core
    localparam int SBD_W = 8;

    // values after reset
    localparam logic [7:0] SBD_ACC_RST = 8'h00;
    localparam logic SBD_FLAG_RST = 1'b0;

    // decrement step and the value that means zero
    localparam logic [7:0] SBD_DEC_STEP = 8'h01;
    localparam logic [7:0] SBD_ZERO = 8'h00;

    // nibble boundary for the half borrow
    localparam int SBD_NIB = 4;

    // cycles of a skipped decrement, counting the dummy
    localparam int SBD_SKIP_CYCLES = 2;

    // operations handed over by the decoder
    typedef enum logic [1:0] {
        SBD_OP_SUB_ACC,
        SBD_OP_SUB_MEM,
        SBD_OP_DEC_MEM,
        SBD_OP_DEC_ACC
    } sbd_op_t;

    // execution state: normal or dummy fetch cycle
    typedef enum logic {
        SBD_ST_RUN,
        SBD_ST_DUMMY
    } sbd_state_t;

    // zero test shared by flag and skip logic
    function automatic logic sbd_is_zero(input logic [7:0] v);
        return v == SBD_ZERO;
    endfunction

endpackage

/* verif/sbd_mem_model.sv */
// data memory byte model on the far side of the execution block
// assumes one addressed byte; the core writes it back with mem_wr_out pulses
`timescale 1ns/1ps
module sbd_mem_model (
    // clock
    input wire logic clock_in,
    // bench preset and core write-back
    input wire logic preset_in,
    input wire logic [7:0] preset_data_in,
    input wire logic wr_in,
    input wire logic [7:0] wdata_in,
    // byte presented as already read
    output logic [7:0] rdata_out
);
    logic [7:0] byte_reg;
    // core write wins so a write-back is never lost to a preset
    always_ff @(posedge clock_in) begin
        if (wr_in) begin
            byte_reg <= wdata_in;
        end else if (preset_in) begin
            byte_reg <= preset_data_in;
        end
    end
    assign rdata_out = byte_reg;
endmodule

/* verif/subtract_borrow_and_decrement_skip_test.sv */
// self-checking bench for the subtract-borrow and decrement-skip block
// assumes the memory model stands in for the addressed data byte
`timescale 1ns/1ps
module subtract_borrow_and_decrement_skip_test;
    import sbd_pkg::*;
    logic clock_in = 1'b0;
    logic rst_in = 1'b1;
    logic op_valid = 1'b0, acc_load = 1'b0, carry_load = 1'b0, carry_data = 1'b0, pre = 1'b0;
    sbd_op_t op = SBD_OP_SUB_ACC;
    logic [7:0] imm = 8'h00, acc_data = 8'h00, pre_data = 8'h00, mem_rd, acc, wdata;
    logic mem_wr, c, hb, z, ov, sc, cz, skip, done;
    logic [7:0] flags, fl0;
    int num_errors = 0;
    int n_tests = 0;
    assign flags = {2'h0, c, hb, z, ov, sc, cz};
    sbd_core dut (.clock_in(clock_in), .rst_in(rst_in), .op_valid_in(op_valid), .op_in(op),
        .imm_in(imm), .mem_data_in(mem_rd), .acc_load_in(acc_load),
        .acc_load_data_in(acc_data), .carry_load_in(carry_load),
        .carry_load_data_in(carry_data), .acc_out(acc), .mem_wr_out(mem_wr),
        .mem_wdata_out(wdata), .carry_flag_out(c), .half_borrow_flag_out(hb),
        .zero_flag_out(z), .overflow_flag_out(ov), .signed_compare_flag_out(sc),
        .combined_zero_flag_out(cz), .skip_out(skip), .done_out(done));
    sbd_mem_model mem (.clock_in(clock_in), .preset_in(pre), .preset_data_in(pre_data),
        .wr_in(mem_wr), .wdata_in(wdata), .rdata_out(mem_rd));
    // clock at 100 ns period
    initial begin
        forever #50 clock_in = ~clock_in;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // preset the byte, offer one op; hold keeps it offered into the dummy cycle
    task automatic run_op(input sbd_op_t o, input logic [7:0] i, input logic [7:0] m,
        input bit hold);
        @(posedge clock_in);
        pre <= 1'b1;
        pre_data <= m;
        @(posedge clock_in);
        pre <= 1'b0;
        op_valid <= 1'b1;
        op <= o;
        imm <= i;
        @(posedge clock_in);
        op_valid <= hold;
        #1;
    endtask
    task automatic load(input logic [7:0] a, input logic cin);
        @(posedge clock_in);
        acc_load <= 1'b1;
        acc_data <= a;
        carry_load <= 1'b1;
        carry_data <= cin;
        @(posedge clock_in);
        acc_load <= 1'b0;
        carry_load <= 1'b0;
    endtask
    // borrow chain and every flag of the immediate subtract
    task automatic test_sub_acc();
        load(8'h10, 1'b1);
        run_op(SBD_OP_SUB_ACC, 8'h10, 8'h00, 1'b0);
        chk(acc, 8'h00);
        chk(flags, 8'h38);
        run_op(SBD_OP_SUB_ACC, 8'h01, 8'h00, 1'b0);
        chk(acc, 8'hFF);
        chk(flags, 8'h02);
        run_op(SBD_OP_SUB_ACC, 8'h00, 8'h00, 1'b0);
        chk(acc, 8'hFE);
        chk({7'h00, c}, 8'h01);
        load(8'h80, 1'b1);
        run_op(SBD_OP_SUB_ACC, 8'h01, 8'h00, 1'b0);
        chk(acc, 8'h7F);
        chk(flags, 8'h26);
    endtask
    // memory destination leaves the accumulator alone
    task automatic test_sub_mem();
        load(8'h05, 1'b1);
        run_op(SBD_OP_SUB_MEM, 8'h00, 8'h07, 1'b0);
        chk({done, mem_wr, 6'h00}, 8'hC0);
        chk(wdata, 8'hFE);
        chk(acc, 8'h05);
        chk({7'h00, c}, 8'h00);
    endtask
    // taken skip: one dummy cycle refuses the next offer, flags untouched
    task automatic test_dec_mem();
        fl0 = flags;
        run_op(SBD_OP_DEC_MEM, 8'h00, 8'h01, 1'b1);
        chk({done, mem_wr, skip, 5'h00}, 8'hE0);
        chk(wdata, 8'h00);
        @(posedge clock_in);
        op_valid <= 1'b0;
        #1;
        chk({done, skip, 6'h00}, 8'h00);
        chk(mem_rd, 8'h00);
        run_op(SBD_OP_DEC_MEM, 8'h00, 8'h00, 1'b0);
        chk({mem_wr, skip, 6'h00}, 8'h80);
        chk(wdata, 8'hFF);
        chk(flags, fl0);
    endtask
    // accumulator destination keeps the memory byte
    task automatic test_dec_acc();
        fl0 = flags;
        run_op(SBD_OP_DEC_ACC, 8'h00, 8'h05, 1'b0);
        chk({done, mem_wr, skip, 5'h00}, 8'h80);
        chk(acc, 8'h04);
        chk(mem_rd, 8'h05);
        run_op(SBD_OP_DEC_ACC, 8'h00, 8'h01, 1'b0);
        chk({mem_wr, skip, 6'h00}, 8'h40);
        chk(acc, 8'h00);
        chk(flags, fl0);
    endtask
    // mid-run reset in the cycle after a dummy cycle clears everything
    task automatic test_reset();
        @(posedge clock_in);
        rst_in <= 1'b1;
        @(posedge clock_in);
        @(posedge clock_in);
        rst_in <= 1'b0;
        #1;
        chk(acc, 8'h00);
        chk(flags, 8'h00);
        chk({done, mem_wr, skip, 5'h00}, 8'h00);
        chk(wdata, 8'h00);
    endtask
    task automatic end_sim();
        $display("errors=%0d checks=%0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (2) @(posedge clock_in);
        rst_in <= 1'b0;
        test_sub_acc();
        test_sub_mem();
        test_dec_mem();
        test_dec_acc();
        test_reset();
        end_sim();
    end
    // watchdog: the tests need well under 100 cycles
    initial begin
        #200000;
        num_errors++;
        end_sim();
    end
endmodule
